// *** verilog/line_mon_pkg.sv ***
// Package: register map, fields and constants of the line monitor
//
// Overview of operation
// RL1 - Reading second status register clears it
// RL2 - Masked visible bits never reach irq/summary
// RL3 - Clock loss flag set on loss, simulation
// RL4 - Change option flags both clock status edges
// RL5 - One-second timer expiry sets tick flag
// RL6 - Summary register: one pending bit per channel
// RL7 - E1 HDB3/CMI violations increment violation counter
// RL8 - AMI coding counts every bipolar violation
// RL9 - T1 B8ZS: real violations, zeros over seven
// RL10 - T1 AMI excess zero: runs over fifteen
// RL11 - Simulation counts every four bits, saturating
// RL12 - Manual mode: freeze rise stops buffer, clears
// RL13 - Violation high byte read drops freeze bit
// RL14 - Auto mode latches violations each second
// RL15 - Software reads latched value within second
// RL16 - PRBS errors counted only while synchronized
// RL17 - PRBS freeze rise stops, clears; high read drops
// RL18 - Auto mode latches PRBS errors each second
// RL19 - First status register also cleared on read
// RL20 - Interrupt output while unmasked bit pending
package line_mon_pkg;
   localparam int num_channels = 4;
   localparam int addr_width = 7;
   localparam int chan_stride = 32;
   localparam logic [4:0] off_irq_status_first = 5'h17;
   localparam logic [4:0] off_irq_status_second = 5'h18;
   localparam logic [4:0] off_cv_low = 5'h19;
   localparam logic [4:0] off_cv_high = 5'h1a;
   localparam logic [4:0] off_prbs_low = 5'h1b;
   localparam logic [4:0] off_prbs_high = 5'h1c;
   localparam logic [4:0] off_config = 5'h1d;
   localparam logic [4:0] off_command = 5'h1e;
   localparam logic [4:0] off_masks = 5'h1f;
   localparam logic [6:0] off_channel_irq_summary = 7'h60;
   localparam logic [7:0] summary_reset = 8'h00;
   localparam int bit_tick_flag = 0;
   localparam int bit_clock_loss_flag = 1;
   localparam int cfg_visible_masked = 0;
   localparam int cfg_change_irq = 1;
   localparam int cfg_excess_zero = 2;
   localparam int cfg_auto_counter = 3;
   localparam int cfg_code_lo = 4;
   localparam int cfg_port_t1 = 6;
   localparam int cfg_alarm_sim = 7;
   localparam int cmd_cv_freeze = 0;
   localparam int cmd_prbs_freeze = 1;
   localparam logic [1:0] code_ami = 2'h0;
   localparam logic [1:0] code_b8zs = 2'h2;
   localparam logic [4:0] zero_limit_b8zs = 5'h07;
   localparam logic [4:0] zero_limit_ami = 5'h0f;
   localparam logic [4:0] zero_limit_hdb3 = 5'h03;
   localparam logic [1:0] sim_bit_period = 2'h3;
   localparam logic [15:0] count_max = 16'hffff;
   localparam int second_cycles = 125000000;
   localparam logic [7:0] unmapped_data = 8'h00;

   typedef struct packed {
      logic bit_valid;
      logic bit_one;
      logic bipolar_violation;
      logic substitution;
      logic prbs_error;
      logic tx_clock_lost;
      logic tx_clock_status;
      logic prbs_sync_status;
      logic [7:0] first_causes;
   } line_events_s;
endpackage : line_mon_pkg

// *** verilog/err_counter.sv ***
// One 16-bit error counter with buffer, freeze and one-second latch
module err_counter
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic inc,
   input wire logic auto_mode,
   input wire logic freeze,
   input wire logic freeze_rise,
   input wire logic tick,
   input wire logic saturate,
   output logic [15:0] buffer
);
   import line_mon_pkg::*;

   logic [15:0] running;

   // RL12 - Running counter clear
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         running <= 16'h0000;
      else if (freeze_rise || (auto_mode && tick))
         running <= 16'h0000;
      else if (inc && !(saturate && running == count_max))
         running <= running + 16'h0001;
   end

   // RL14 - Buffer latch per mode
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         buffer <= 16'h0000;
      else if (auto_mode)
      begin
         if (tick)
            buffer <= running;
      end
      else if (!freeze)
         buffer <= running;
   end
endmodule : err_counter

// *** verilog/line_mon.sv ***
// Four-channel line error counters and interrupt status, Avalon-MM slave
//
// Implementation choice: the Avalon-MM register port.
module line_mon
#(
   parameter int second_count = line_mon_pkg::second_cycles
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [line_mon_pkg::addr_width-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   output logic [7:0] readdata,
   output logic waitrequest,
   output logic irq,
   input wire line_mon_pkg::line_events_s [3:0] events
);
   import line_mon_pkg::*;

   logic ack;
   logic [1:0] chan;
   logic [4:0] reg_off;
   logic [7:0] next_readdata;
   logic [3:0] pending;
   logic [3:0] summary;

   assign chan = address[6:5];
   assign reg_off = address[4:0];

   ////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then ack
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ack <= 1'b0;
      else
         ack <= (read || write) && !ack;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && !ack && waitrequest);
   end

   genvar g;
   generate
      for (g = 0; g < num_channels; g++)
      begin : ch
         logic [7:0] cfg;
         logic [7:0] cmd;
         logic [7:0] mask_first;
         logic [1:0] mask_second;
         logic [7:0] stat_first;
         logic [1:0] stat_second;
         logic [2:0] sync_tcs;
         logic [2:0] sync_prbs;
         logic tcs_q;
         logic [1:0] cmd_q;
         logic [31:0] sec_cnt;
         logic tick;
         logic [4:0] zeros;
         logic [1:0] sim_cnt;
         logic cv_inc;
         logic zero_run;
         logic [4:0] zero_lim;
         logic t1;
         logic [1:0] code;
         logic sim;
         logic vis;
         logic sel;
         logic rd_first;
         logic rd_second;
         logic rd_cvh;
         logic rd_prh;
         logic tcs;
         logic prbs_sync;
         logic [15:0] cv_buf;
         logic [15:0] pr_buf;
         logic [1:0] freeze_rise;

         assign sel = chan == 2'(g);
         assign rd_first = read && ack && sel && reg_off == off_irq_status_first;
         assign rd_second = read && ack && sel &&
                            reg_off == off_irq_status_second;
         assign rd_cvh = read && ack && sel && reg_off == off_cv_high;
         assign rd_prh = read && ack && sel && reg_off == off_prbs_high;
         assign t1 = cfg[cfg_port_t1];
         assign code = cfg[cfg_code_lo+1:cfg_code_lo];
         assign sim = cfg[cfg_alarm_sim];
         assign vis = cfg[cfg_visible_masked];
         assign tcs = sync_tcs[2];
         assign prbs_sync = sync_prbs[2];
         assign freeze_rise = cmd[1:0] & ~cmd_q;

         // Software-written control registers
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               cfg <= 8'h00;
               mask_first <= 8'hff;
               mask_second <= 2'h3;
            end
            else if (write && ack && sel)
            begin
               if (reg_off == off_config)
                  cfg <= writedata;
               if (reg_off == off_masks)
                  mask_second <= writedata[1:0];
               if (reg_off == off_irq_status_first)
                  mask_first <= writedata;
            end
         end

         // RL13 - Freeze bits self-clear
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               cmd <= 8'h00;
            else
            begin
               if (write && ack && sel && reg_off == off_command)
                  cmd <= {6'h00, writedata[1:0]};
               else
               begin
                  if (rd_cvh)
                     cmd[cmd_cv_freeze] <= 1'b0;
                  if (rd_prh)
                     cmd[cmd_prbs_freeze] <= 1'b0;
               end
            end
         end

         // Status pin synchronisers
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
            begin
               sync_tcs <= 3'h0;
               sync_prbs <= 3'h0;
               tcs_q <= 1'b0;
               cmd_q <= 2'h0;
            end
            else
            begin
               sync_tcs <= {sync_tcs[1:0], events[g].tx_clock_status};
               sync_prbs <= {sync_prbs[1:0], events[g].prbs_sync_status};
               tcs_q <= tcs;
               cmd_q <= cmd[1:0];
            end
         end

         // RL5 - One-second timer
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               sec_cnt <= 32'h0;
            else if (sec_cnt == 32'(second_count - 1))
               sec_cnt <= 32'h0;
            else
               sec_cnt <= sec_cnt + 32'h1;
         end
         assign tick = sec_cnt == 32'(second_count - 1);

         // RL1 - Status set wins over read clear
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               stat_second <= 2'h0;
            else
            begin
               stat_second <= rd_second ? 2'h0 : stat_second;
               if (tick && (vis || !mask_second[bit_tick_flag]))
                  stat_second[bit_tick_flag] <= 1'b1;
               // RL3 - Clock loss or simulation
               if (((events[g].tx_clock_lost && tcs) || sim ||
                   // RL4 - Either status edge
                   (cfg[cfg_change_irq] && tcs != tcs_q)) &&
                   (vis || !mask_second[bit_clock_loss_flag]))
                  stat_second[bit_clock_loss_flag] <= 1'b1;
            end
         end

         // RL19 - First register clear on read
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               stat_first <= 8'h00;
            else
               stat_first <= (rd_first ? 8'h00 : stat_first) |
                             (events[g].first_causes &
                              (~mask_first | {8{vis}}));
         end

         // RL2 - Masked bits kept out
         assign pending[g] = |(stat_first & ~mask_first) |
                             |(stat_second & ~mask_second);

         // Zero run length
         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               zeros <= 5'h0;
            else if (events[g].bit_valid)
               zeros <= events[g].bit_one ? 5'h0 :
                        (zeros == 5'h1f ? zeros : zeros + 5'h1);
         end

         always_comb
         begin
            zero_lim = t1 ? (code == code_b8zs ? zero_limit_b8zs :
                             zero_limit_ami) : zero_limit_hdb3;
            // RL9 - RL10 - Run beyond limit, counted once
            zero_run = cfg[cfg_excess_zero] && events[g].bit_valid &&
                       !events[g].bit_one && zeros == zero_lim &&
                       (t1 || code != code_ami);
            // RL7 - RL8 - Violations by coding
            cv_inc = zero_run || (events[g].bipolar_violation &&
                     !(t1 && code == code_b8zs && events[g].substitution));
            // RL11 - Simulation every fourth bit
            if (sim)
               cv_inc = events[g].bit_valid && sim_cnt == sim_bit_period;
         end

         always_ff @(posedge mclk or posedge rst)
         begin
            if (rst)
               sim_cnt <= 2'h0;
            else if (events[g].bit_valid)
               sim_cnt <= sim_cnt + 2'h1;
         end

         // RL12 - RL14 - Violation counter
         err_counter u_cv
         (
            .mclk(mclk),
            .rst(rst),
            .inc(cv_inc),
            .auto_mode(cfg[cfg_auto_counter]),
            .freeze(cmd[cmd_cv_freeze]),
            .freeze_rise(freeze_rise[cmd_cv_freeze]),
            .tick(tick),
            .saturate(sim),
            .buffer(cv_buf)
         );

         // RL16 - RL17 - RL18 - PRBS counter
         err_counter u_prbs
         (
            .mclk(mclk),
            .rst(rst),
            .inc(events[g].prbs_error && prbs_sync),
            .auto_mode(cfg[cfg_auto_counter]),
            .freeze(cmd[cmd_prbs_freeze]),
            .freeze_rise(freeze_rise[cmd_prbs_freeze]),
            .tick(tick),
            .saturate(1'b0),
            .buffer(pr_buf)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // RL6 - Summary register
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         summary <= summary_reset[3:0];
      else
         summary <= pending;
   end

   // RL20 - Interrupt output
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |pending;
   end

   always_comb
   begin
      next_readdata = unmapped_data;
      if (address == off_channel_irq_summary)
         next_readdata = {4'h0, summary};
      else
      begin
         case (chan)
            2'd0: next_readdata = sel_data(0);
            2'd1: next_readdata = sel_data(1);
            2'd2: next_readdata = sel_data(2);
            default: next_readdata = sel_data(3);
         endcase
      end
   end

   function automatic logic [7:0] pick(input logic [4:0] off,
      input logic [7:0] s1, input logic [1:0] s2,
      input logic [15:0] cv, input logic [15:0] pr,
      input logic [7:0] cf, input logic [7:0] cm);
      case (off)
         off_irq_status_first: pick = s1;
         off_irq_status_second: pick = {6'h00, s2};
         off_cv_low: pick = cv[7:0];
         off_cv_high: pick = cv[15:8];
         off_prbs_low: pick = pr[7:0];
         off_prbs_high: pick = pr[15:8];
         off_config: pick = cf;
         off_command: pick = cm;
         default: pick = unmapped_data;
      endcase
   endfunction : pick

   function automatic logic [7:0] sel_data(input int i);
      sel_data = unmapped_data;
   endfunction : sel_data

   logic [7:0] chan_data [4];
   generate
      for (g = 0; g < num_channels; g++)
      begin : rd
         assign chan_data[g] = pick(reg_off, ch[g].stat_first,
            ch[g].stat_second, ch[g].cv_buf, ch[g].pr_buf,
            ch[g].cfg, ch[g].cmd);
      end
   endgenerate

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         readdata <= 8'h00;
      else if (read && !ack)
         readdata <= (address == off_channel_irq_summary) ?
                     next_readdata : chan_data[chan];
   end
endmodule : line_mon

// *** sim/line_mon_properties.sv ***
// Checker: bus handshake and interrupt properties at the monitor ports
module line_mon_properties
import line_mon_pkg::*;
#(
   parameter int second_count = 100
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [line_mon_pkg::addr_width-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [7:0] writedata,
   input wire logic [7:0] readdata,
   input wire logic waitrequest,
   input wire logic irq
);
   logic req;

   assign req = read || write;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////
   sequence s_req;
      req && waitrequest;
   endsequence
   sequence s_ack;
      req && !waitrequest;
   endsequence
   sequence s_rd_ack;
      read && !waitrequest;
   endsequence

   property p_answer;
      s_req |-> ##[1:2] s_ack;
   endproperty
   a_answer: assert property (p_answer)
      else $error("request not answered within two cycles");

   property p_wait_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low for more than one cycle");

   property p_wait_cause;
      !waitrequest |-> req;
   endproperty
   a_wait_cause: assert property (p_wait_cause)
      else $error("waitrequest low without a request");

   property p_data_hold;
      $changed(readdata) |-> s_rd_ack;
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("readdata changed outside a read answer");

   property p_unmapped;
      s_rd_ack ##0 (address[4:0] < off_irq_status_first &&
         address != off_channel_irq_summary) |-> readdata == unmapped_data;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned data");

   property p_summary_top;
      s_rd_ack ##0 (address == off_channel_irq_summary)
         |-> readdata[7:4] == 4'h0;
   endproperty
   a_summary_top: assert property (p_summary_top)
      else $error("summary upper bits not zero");

   property p_irq_fall;
      $fell(irq) |-> $past(req) || $past(req, 2) || $past(req, 3);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq dropped without a register access");

   property p_irq_reset;
      $fell(rst) |-> !irq [*2];
   endproperty
   a_irq_reset: assert property (p_irq_reset)
      else $error("irq high right after reset");
endmodule : line_mon_properties

bind line_mon line_mon_properties #(.second_count(second_count)) chk (
   .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .irq(irq));

// *** sim/line_mon_bench.sv ***
// Bench: self-checking test of the four-channel line monitor
module line_mon_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import line_mon_pkg::*;
   localparam int second_count = 100;
   logic mclk, rst, read, write, waitrequest, irq;
   logic [addr_width-1:0] address;
   logic [7:0] writedata, readdata;
   line_events_s [3:0] ev;
   int fails = 0, comparisons = 0, cycles = 0;

   line_mon #(.second_count(second_count)) uut (
      .mclk(mclk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .events(ev));

   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up

   task automatic cmp(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   function automatic logic [6:0] ra(input int ch, input logic [4:0] off);
      return {ch[1:0], off};
   endfunction : ra

   function automatic int over(input int z, input int lim);
      return (z > lim) ? 1 : 0;
   endfunction : over

   task automatic bus(input logic w, input logic [6:0] a,
      input logic [7:0] wd, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      address <= a;
      writedata <= wd;
      read <= !w;
      write <= w;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      d = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      bus(1'b0, a, 8'h00, d);
   endtask : rd

   task automatic wr(input logic [6:0] a, input logic [7:0] wd);
      logic [7:0] d;
      bus(1'b1, a, wd, d);
   endtask : wr

   task automatic rd16(input int ch, input logic [4:0] off,
      output logic [15:0] v);
      rd(ra(ch, off), v[7:0]);
      rd(ra(ch, off + 5'h01), v[15:8]);
   endtask : rd16

   task automatic grab(input int ch, input int b, input logic [4:0] off,
      output logic [15:0] v);
      wr(ra(ch, off_command), 8'h01 << b);
      rd16(ch, off, v);
   endtask : grab

   task automatic bits(input int ch, input int n, input logic [3:0] f);
      repeat (n)
      begin
         @(posedge mclk);
         ev[ch][15:11] <= {1'b1, f};
      end
      @(posedge mclk);
      ev[ch][15:11] <= 5'h00;
   endtask : bits

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask : idle

   task automatic wait_tick(input int ch);
      logic [7:0] d;
      int n;
      n = 0;
      rd(ra(ch, off_irq_status_second), d);
      d = 8'h00;
      while (d[bit_tick_flag] !== 1'b1 && n < 80)
      begin
         rd(ra(ch, off_irq_status_second), d);
         n++;
      end
   endtask : wait_tick

   ////////////////////////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         fails++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////
   initial
   begin
      logic [7:0] d;
      logic [15:0] v;
      int c, e, n, m, lim;
      rst = 1'b1;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = 8'h00;
      ev = '0;
      n = $urandom(32'h622e);
      idle(2);
      rst <= 1'b0;
      rd(off_channel_irq_summary, d);
      cmp("summary reset", summary_reset, d);
      wr(7'h05, 8'hff);
      rd(7'h05, d);
      cmp("unmapped", unmapped_data, d);
      c = $urandom % 4;
      wr(ra(c, off_masks), 8'h00);
      rd(ra(c, off_irq_status_second), d);
      idle(second_count + 10);
      cmp("irq set", 1, irq);
      rd(off_channel_irq_summary, d);
      cmp("summary", 16'h1 << c, d);
      rd(ra(c, off_irq_status_second), d);
      cmp("tick", 1, d[bit_tick_flag]);
      rd(ra(c, off_irq_status_second), d);
      cmp("status cleared", 0, d[1:0]);
      idle(3);
      cmp("irq clear", 0, irq);
      wr(ra(c, off_masks), 8'h03);
      e = (c + 1) % 4;
      wr(ra(e, off_config), 8'h01);
      idle(second_count + 10);
      cmp("irq masked", 0, irq);
      rd(off_channel_irq_summary, d);
      cmp("summary masked", 0, d);
      rd(ra(e, off_irq_status_second), d);
      cmp("visible tick", 1, d[bit_tick_flag]);
      wr(ra(e, off_config), 8'h00);
      wr(ra(0, off_masks), 8'h00);
      ev[0].tx_clock_status <= 1'b1;
      idle(6);
      rd(ra(0, off_irq_status_second), d);
      @(posedge mclk);
      ev[0].tx_clock_lost <= 1'b1;
      @(posedge mclk);
      ev[0].tx_clock_lost <= 1'b0;
      idle(2);
      rd(ra(0, off_irq_status_second), d);
      cmp("clock loss", 1, d[bit_clock_loss_flag]);
      wr(ra(0, off_config), 8'h02);
      for (int t = 0; t < 2; t++)
      begin
         rd(ra(0, off_irq_status_second), d);
         ev[0].tx_clock_status <= t[0];
         idle(6);
         rd(ra(0, off_irq_status_second), d);
         cmp("status change", 1, d[bit_clock_loss_flag]);
      end
      wr(ra(0, off_config), 8'h80);
      rd(ra(0, off_irq_status_second), d);
      rd(ra(0, off_irq_status_second), d);
      cmp("sim loss", 1, d[bit_clock_loss_flag]);
      grab(0, cmd_cv_freeze, off_cv_low, v);
      bits(0, 40, 4'b0000);
      grab(0, cmd_cv_freeze, off_cv_low, v);
      cmp("sim count", 16'd10, v);
      for (int t = 0; t < 2; t++)
      begin
         c = $urandom % 4;
         n = 1 + $urandom % 30;
         m = 1 + $urandom % 30;
         wr(ra(c, off_config), t ? 8'h40 : 8'h00);
         grab(c, cmd_cv_freeze, off_cv_low, v);
         bits(c, n, 4'b1100);
         wr(ra(c, off_command), 8'h01 << cmd_cv_freeze);
         bits(c, m, 4'b1100);
         rd16(c, off_cv_low, v);
         cmp("cv frozen", 16'(n), v);
         rd(ra(c, off_command), d);
         cmp("cv freeze bit", 0, d[cmd_cv_freeze]);
         grab(c, cmd_cv_freeze, off_cv_low, v);
         cmp("cv restarted", 16'(m), v);
      end
      for (int t = 0; t < 2; t++)
      begin
         lim = t ? int'(zero_limit_ami) : int'(zero_limit_b8zs);
         wr(ra(t, off_config), t ? 8'h44 : 8'h64);
         bits(t, 1, 4'b1000);
         grab(t, cmd_cv_freeze, off_cv_low, v);
         n = lim + 1 + $urandom % 4;
         bits(t, n, 4'b0000);
         bits(t, 1, 4'b1000);
         bits(t, lim, 4'b0000);
         bits(t, 1, t ? 4'b1000 : 4'b1110);
         grab(t, cmd_cv_freeze, off_cv_low, v);
         cmp("zero runs", 16'(over(n, lim) + over(lim, lim)), v);
      end
      wr(ra(3, off_config), 8'h00);
      grab(3, cmd_prbs_freeze, off_prbs_low, v);
      bits(3, 5 + $urandom % 9, 4'b0001);
      ev[3].prbs_sync_status <= 1'b1;
      idle(5);
      n = 1 + $urandom % 30;
      bits(3, n, 4'b0001);
      grab(3, cmd_prbs_freeze, off_prbs_low, v);
      cmp("prbs count", 16'(n), v);
      rd(ra(3, off_command), d);
      cmp("prbs freeze bit", 0, d[cmd_prbs_freeze]);
      wr(ra(3, off_masks), 8'h00);
      wr(ra(3, off_config), 8'h08);
      wait_tick(3);
      n = 1 + $urandom % 40;
      bits(3, n, 4'b1101);
      wait_tick(3);
      rd16(3, off_cv_low, v);
      cmp("cv latched", 16'(n), v);
      rd16(3, off_prbs_low, v);
      cmp("prbs latched", 16'(n), v);
      wrap_up();
   end
endmodule : line_mon_bench
